// >>> bench/cid_decode_monitor.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Decode checker
// ------------------------------------------------------------
module cid_decode_chk (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        instr_valid,
   input wire logic [7:0]  opcode,
   input wire logic [7:0]  byte2,
   input wire logic [15:0] pc,
   input wire logic        bit_value,
   input wire logic [5:0]  flags_in,
   input wire logic        busy,
   input wire logic        done,
   input wire logic [15:0] next_pc,
   input wire logic [5:0]  flags_out,
   input wire logic [1:0]  op_size,
   input wire logic [1:0]  addr_mode,
   input wire logic        auto_inc,
   input wire logic        long_index,
   input wire logic [7:0]  dest_addr,
   input wire logic        dest_misaligned,
   input wire logic [7:0]  ptr_addr,
   input wire logic        signed_op,
   input wire logic [10:0] bit_number,
   input wire logic [5:0]  state_count,
   input wire logic        reset_pin_low
);
   wire logic take;
   // Done cycle excluded: requests are only issued after it
   assign take = rst_n && instr_valid && !busy && !done;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_take(logic [7:0] op);
      take && opcode == op;
   endsequence
   a_rst_vector: assert property (s_take(cid_pkg::OP_SW_RESET) |=> next_pc == 16'h2080
      && flags_out == 6'h00 && reset_pin_low) else $error("sw reset outputs wrong");
   a_je_target: assert property (s_take(cid_pkg::OP_JE) ##0 flags_in[5] |=> flags_out ==
      $past(flags_in) && next_pc == $past(pc) + 16'h0002 + 16'($signed($past(byte2))))
      else $error("equal jump target or flags wrong");
   a_jle_count: assert property (s_take(cid_pkg::OP_JLE) |=> state_count ==
      (($past(flags_in[4]) | $past(flags_in[5])) ? 6'h08 : 6'h04)) else $error("jle decision wrong");
   a_jh_count: assert property (s_take(cid_pkg::OP_JH) |=> state_count ==
      (($past(flags_in[3]) & ~$past(flags_in[5])) ? 6'h08 : 6'h04)) else $error("jh decision wrong");
   a_trap_clear: assert property (take && (opcode == 8'hDC || opcode == 8'hD4) |=>
      !flags_out[1]) else $error("trap flag not cleared");
   a_bit_select: assert property (take && opcode[7:4] == 4'h3 |=> bit_number ==
      {$past(byte2), $past(opcode[2:0])} && state_count ==
      (($past(bit_value) ^ $past(opcode[3])) ? 6'h05 : 6'h09)) else $error("bit jump wrong");
   a_mode_ptr: assert property (s_take(8'h66) |=> addr_mode == 2'h2 &&
      auto_inc == $past(byte2[0]) && ptr_addr == {$past(byte2[7:1]), 1'b0})
      else $error("indirect mode decode wrong");
   a_signed_mul: assert property (s_take(8'hFE) ##1 s_take(8'h6C) |=> signed_op &&
      state_count == 6'h1D) else $error("prefixed multiply wrong");
   a_long_shift: assert property (s_take(cid_pkg::OP_DOUBLE_WORD_LEFT_SHIFT) |=> op_size == 2'h2)
      else $error("long shift size wrong");
   a_long_index: assert property (s_take(8'h6F) |=> addr_mode == 2'h3 &&
      long_index == $past(byte2[0])) else $error("indexed mode decode wrong");
   a_mul_layout: assert property (s_take(8'h6C) |=> op_size == 2'h1 &&
      dest_addr == $past(byte2) && dest_misaligned == ($past(byte2[1:0]) != 2'h0))
      else $error("word multiply layout wrong");
   a_mulb_layout: assert property (s_take(8'h7C) |=> op_size == 2'h0 &&
      dest_misaligned == $past(byte2[0])) else $error("byte multiply layout wrong");
endmodule // cid_decode_chk

bind cid_decode cid_decode_chk u_chk (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
   .opcode(opcode), .byte2(byte2), .pc(pc), .bit_value(bit_value), .flags_in(flags_in),
   .busy(busy), .done(done), .next_pc(next_pc), .flags_out(flags_out), .op_size(op_size),
   .addr_mode(addr_mode), .auto_inc(auto_inc), .long_index(long_index),
   .dest_addr(dest_addr), .dest_misaligned(dest_misaligned),
   .ptr_addr(ptr_addr), .signed_op(signed_op),
   .bit_number(bit_number), .state_count(state_count), .reset_pin_low(reset_pin_low));

// >>> bench/cid_decode_tb_top.sv
`timescale 1ns/1ps
module cid_decode_tb_top;
   typedef struct packed {logic [15:0] pc; logic [5:0] cnt; logic [5:0] fl; logic [2:0] m;} cid_note_t;
   logic clk = 0, rst_n = 0, instr_valid = 0, operand_external = 0, bit_value, busy, done;
   logic [7:0] opcode = 0, byte2 = 0, byte3 = 0, d;
   logic [15:0] pc = 0, next_pc, p;
   logic [5:0] flags_in = 0, flags_out, state_count, f;
   int bad_count = 0, cmp_count = 0, i, k;
   cid_note_t q[$], n, w;
   always #5 clk = ~clk;
   cid_decode DUT (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .opcode(opcode),
      .byte2(byte2), .byte3(byte3), .pc(pc), .bit_value(bit_value), .flags_in(flags_in),
      .operand_external(operand_external), .busy(busy), .done(done), .next_pc(next_pc),
      .flags_out(flags_out), .op_size(), .addr_mode(), .auto_inc(), .long_index(),
      .dest_addr(), .ptr_addr(), .dest_misaligned(), .signed_op(), .bit_number(),
      .state_count(state_count), .reset_pin_low());
   cid_rf_model u_rf (.opcode(opcode), .byte2(byte2), .bit_value(bit_value));
   // ------------------------------------------------------------
   // Checking
   // ------------------------------------------------------------
   task final_report;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task cmp16(input logic [15:0] e, input logic [15:0] a);
      cmp_count++;
      if (a !== e) begin
         bad_count++;
         $display("[ERR] %0t exp %h got %h", $time, e, a);
      end
   endtask
   task cmp6(input logic [5:0] e, input logic [5:0] a);
      cmp16({10'h000, e}, {10'h000, a});
   endtask
   // Results stand until the next instruction, so sampling at done is safe
   always @(negedge clk) if (done === 1'b1 && q.size() > 0) begin
      n = q.pop_front();
      if (n.m[0]) cmp16(n.pc, next_pc);
      if (n.m[1]) cmp6(n.fl, flags_out);
      if (n.m[2]) cmp6(n.cnt, state_count);
   end
   // ------------------------------------------------------------
   // Driving
   // ------------------------------------------------------------
   task issue(input logic pre, input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3,
              input logic [15:0] ap, input logic [5:0] af, input logic ext, input cid_note_t nt);
      int t;
      @(negedge clk);
      {pc, flags_in, operand_external, byte2, byte3, instr_valid} = {ap, af, ext, b2, b3, 1'b1};
      opcode = pre ? 8'hFE : op;
      // Prefix is taken in one cycle without busy
      if (pre) begin
         @(negedge clk);
         opcode = op;
      end
      q.push_back(nt);
      @(negedge clk);
      instr_valid = 0;
      for (t = 0; t < 64 && done !== 1'b1; t++) @(negedge clk);
      if (done !== 1'b1) cmp16(16'h0001, 16'h0000);
   endtask
   function automatic cid_note_t jn(logic [7:0] op, logic [7:0] dv, logic [5:0] fv, logic [15:0] pv);
      logic b;
      cid_note_t r;
      case (op[2:0])
         3'h0: b = fv[0];
         3'h1: b = fv[3] & ~fv[5];
         3'h2: b = fv[4] | fv[5];
         3'h3: b = fv[3];
         3'h4: b = fv[1];
         3'h5: b = fv[2];
         3'h6: b = ~fv[4];
         default: b = fv[5];
      endcase
      b = op[3] ? b : ~b;
      r.pc = pv + 16'h0002 + (b ? 16'($signed(dv)) : 16'h0000);
      r.cnt = b ? 6'h08 : 6'h04;
      r.fl = (op[2:0] == 3'h4) ? (fv & 6'h3D) : fv;
      r.m = 3'h7;
      return r;
   endfunction
   initial begin
      #200000;
      cmp16(16'h0001, 16'h0000);
      final_report;
   end
   initial begin
      void'($urandom(32'he0a5c8ee));
      for (i = 0; i < 2048; i++) u_rf.bit_mem[i] = 1'($urandom);
      repeat (5) @(negedge clk);
      rst_n = 1;
      for (k = 0; k < 48; k++) begin
         {d, p} = 24'($urandom);
         f = (k < 16) ? 6'h3F : (k < 32) ? 6'h00 : 6'($urandom);
         issue(0, 8'hD0 + 8'(k % 16), d, 8'h00, p, f, 0, jn(8'hD0 + 8'(k % 16), d, f, p));
      end
      $display("test conditional jumps done");
      for (k = 0; k < 32; k++) begin
         {d, p} = 24'($urandom);
         byte2 = 8'($urandom);
         w = jn(8'hDF, d, {u_rf.bit_mem[{byte2, k[2:0]}] == k[3], 5'h00}, p + 16'h0001);
         w.cnt = w.cnt + 6'h01;
         w.m = 3'h5;
         issue(0, 8'h30 + 8'(k % 16), byte2, d, p, 6'h00, 0, w);
      end
      $display("test bit jumps done");
      issue(0, 8'h6C, 8'h20, 8'h30, 16'h0100, 6'h00, 0, {16'h0, 6'h19, 6'h0, 3'h4});
      issue(1, 8'h6C, 8'h20, 8'h30, 16'h0100, 6'h00, 0, {16'h0, 6'h1D, 6'h0, 3'h4});
      issue(0, 8'h6C, 8'h20, 8'h30, 16'h0100, 6'h00, 0, {16'h0, 6'h19, 6'h0, 3'h4});
      issue(0, 8'h6E, 8'h10, 8'h30, 16'h0100, 6'h00, 0, {16'h0, 6'h1B, 6'h0, 3'h4});
      issue(0, 8'h6E, 8'h10, 8'h30, 16'h0100, 6'h00, 1, {16'h0, 6'h20, 6'h0, 3'h4});
      issue(0, 8'h6E, 8'h11, 8'h30, 16'h0100, 6'h00, 0, {16'h0, 6'h1C, 6'h0, 3'h4});
      issue(0, 8'h7C, 8'h20, 8'h30, 16'h0100, 6'h00, 0, {16'h0, 6'h11, 6'h0, 3'h4});
      issue(0, 8'h6F, 8'h11, 8'h30, 16'h0100, 6'h00, 0, {16'h0, 6'h1C, 6'h0, 3'h4});
      issue(0, 8'h6C, 8'h22, 8'h30, 16'h0100, 6'h00, 0, {16'h0, 6'h19, 6'h0, 3'h4});
      issue(0, 8'h7C, 8'h21, 8'h30, 16'h0100, 6'h00, 0, {16'h0, 6'h11, 6'h0, 3'h4});
      issue(0, 8'h66, 8'h13, 8'h30, 16'h0100, 6'h00, 0, {16'h0, 6'h07, 6'h0, 3'h4});
      issue(0, 8'h0D, 8'h05, 8'h30, 16'h0100, 6'h00, 0, {16'h0, 6'h07, 6'h0, 3'h4});
      $display("test arithmetic done");
      issue(0, 8'hFF, 8'h00, 8'h00, 16'h0200, 6'h3F, 0, {16'h2080, 6'h10, 6'h0, 3'h7});
      $display("test software reset done");
      final_report;
   end
endmodule // cid_decode_tb_top

// >>> bench/cid_rf_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Register-file bit store seen by the bit-test jumps
// ------------------------------------------------------------
module cid_rf_model (
   input  wire logic [7:0] opcode,
   input  wire logic [7:0] byte2,
   output logic            bit_value
);
   logic            bit_mem [0:2047];
   wire logic [10:0] bit_sel;
   // Bit number is the second byte above the opcode's low three bits
   assign bit_sel   = {byte2, opcode[2:0]};
   assign bit_value = bit_mem[bit_sel];
endmodule // cid_rf_model

// >>> verilog/cid_cond.sv
`timescale 1ns/1ps
module cid_cond (
   cid_flag_if.cond f
);
   wire z  = f.flags[cid_pkg::FLAG_Z];
   wire n  = f.flags[cid_pkg::FLAG_N];
   wire c  = f.flags[cid_pkg::FLAG_C];
   wire v  = f.flags[cid_pkg::FLAG_V];
   wire vt = f.flags[cid_pkg::FLAG_VT];
   wire st = f.flags[cid_pkg::FLAG_ST];
   wire is_jbc = (f.opcode[7:3] == cid_pkg::OP_JBC_BASE[7:3]);
   wire is_jbs = (f.opcode[7:3] == cid_pkg::OP_JBS_BASE[7:3]);
   wire jle_c  = n | z;
   wire jh_c   = c & ~z;
   assign f.taken =
      is_jbc ? ~f.bit_value :
      is_jbs ?  f.bit_value :
      (f.opcode == cid_pkg::OP_JLE)  ?  jle_c :
      (f.opcode == cid_pkg::OP_JGT)  ? ~jle_c :
      (f.opcode == cid_pkg::OP_JH)   ?  jh_c  :
      (f.opcode == cid_pkg::OP_JNH)  ? ~jh_c  :
      (f.opcode == cid_pkg::OP_JE)   ?  z     :
      (f.opcode == cid_pkg::OP_JNE)  ? ~z     :
      (f.opcode == cid_pkg::OP_JV)   ?  v     :
      (f.opcode == cid_pkg::OP_JNV)  ? ~v     :
      (f.opcode == cid_pkg::OP_JST)  ?  st    :
      (f.opcode == cid_pkg::OP_JNST) ? ~st    :
      (f.opcode == cid_pkg::OP_JVT)  ?  vt    :
      (f.opcode == cid_pkg::OP_JUMP_ON_TRAP_CLEAR) ? ~vt    :
      (f.opcode == cid_pkg::OP_JC)   ?  c     :
      (f.opcode == cid_pkg::OP_JNC)  ? ~c     :
      (f.opcode == cid_pkg::OP_JGE)  ?  n     :
      (f.opcode == cid_pkg::OP_JLT)  ? ~n     : 1'b0;
endmodule : cid_cond

// >>> verilog/cid_decode.sv
`timescale 1ns/1ps
//Contract
// - Byte suffix means byte operation, else word, operands aligned to type.
// - Destination and second source in register file; first source anywhere.
// - Word multiply/divide results go to two words, double-word aligned.
// - Byte multiply/divide/sign-extend results go to two bytes, word aligned.
// - Signed less-equal jumps on N or Z; greater-than only both clear.
// - Unsigned higher jumps on C and not Z; complement otherwise.
// - Both trap-flag jumps test then clear the trap flag.
// - Bit-clear jump branches when selected register-file bit is zero.
// - Bit-test jumps select one of 2048 register-file bits.
// - Relative displacements are signed two's complement added to PC.
// - Long-suffix shifts operate on a 32-bit double word.
// - Software reset pulls reset low, clears six flags, restarts at 2080h.
// - Second byte lsb picks plain/short versus auto-increment/long mode.
// - Pointer register address ignores second byte lsb, always even.
// - FE prefix makes next multiply/divide signed.
// - Arithmetic opcode low bits give direct, immediate, indirect, indexed.
// - Multiply and divide take their listed state counts.
// - Indirect/indexed take short count internal, longer count external.
module cid_decode (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        instr_valid,
   input  wire logic [7:0]  opcode,
   input  wire logic [7:0]  byte2,
   input  wire logic [7:0]  byte3,
   input  wire logic [15:0] pc,
   input  wire logic        bit_value,
   input  wire logic        operand_external,
   input  wire logic [5:0]  flags_in,
   output logic             busy,
   output logic             done,
   output logic [15:0]      next_pc,
   output logic [5:0]       flags_out,
   output logic [1:0]       op_size,
   output logic [1:0]       addr_mode,
   output logic             auto_inc,
   output logic             long_index,
   output logic [7:0]       dest_addr,
   output logic [7:0]       ptr_addr,
   output logic             dest_misaligned,
   output logic             signed_op,
   output logic [10:0]      bit_number,
   output logic [5:0]       state_count,
   output logic             reset_pin_low
);
   // ------------------------------------------------------------
   // State machine
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      CID_IDLE = 3'b001,
      CID_EXEC = 3'b010,
      CID_RST  = 3'b100
   } cid_state_t;

   cid_state_t  state_q;
   logic        prefix_q;
   logic [5:0]  cnt_q;

   cid_flag_if  fl ();
   assign fl.opcode    = opcode;
   assign fl.flags     = flags_in;
   assign fl.bit_value = bit_value;

   cid_cond u_cond (
      .f (fl)
   );

   // ------------------------------------------------------------
   // Classification
   // ------------------------------------------------------------
   wire is_prefix  = (opcode == cid_pkg::OP_SIGNED_PREFIX);
   wire is_bitjmp  = (opcode[7:4] == cid_pkg::OP_JBC_BASE[7:4]);
   wire is_condjmp = (opcode[7:4] == cid_pkg::OP_JNST[7:4]);
   wire is_jmp     = is_bitjmp | is_condjmp;
   wire is_vtjmp   = (opcode == cid_pkg::OP_JVT) | (opcode == cid_pkg::OP_JUMP_ON_TRAP_CLEAR);
   wire is_rst     = (opcode == cid_pkg::OP_SW_RESET);
   // Shifts sit at 08h-0Eh except 0Bh; 05h-07h are single-register operations
   wire is_shift   = (opcode[7:4] == 4'h0) & opcode[3]
                     & (opcode[1:0] != 2'h3);
   wire is_shift_b = (opcode[7:4] == 4'h1) & (opcode[3:2] == 2'h2)
                     & (opcode[1:0] != 2'h3);
   wire is_long    = is_shift & opcode[2];
   wire is_single  = (opcode[7:5] == 3'h0) & (opcode[3:2] == 2'h0)
                     & (opcode[1:0] != 2'h0) | (opcode[7:4] < 4'h2)
                     & (opcode[3:0] == 4'h6 || opcode[3:0] == 4'h5
                        || opcode[3:0] == 4'h7);
   wire is_byte_sng = (opcode[7:4] == 4'h1);
   // Arithmetic group: base opcodes with low two bits = mode
   wire [7:0] base = {opcode[7:2], 2'h0};
   wire is_mulw  = (base == cid_pkg::OP_MULU2_BASE) | (base == cid_pkg::OP_MULU3_BASE);
   wire is_mulb  = (base == cid_pkg::OP_MULUB2_BASE) | (base == cid_pkg::OP_MULUB3_BASE);
   wire is_divw  = (base == cid_pkg::OP_DIVU_BASE);
   wire is_divb  = (base == cid_pkg::OP_DIVUB_BASE);
   wire is_three = (opcode[7:5] == 3'h2);
   wire is_arith = (opcode[7:4] >= 4'h4) & (opcode[7:4] <= 4'hB) & ~is_mulb
                   | is_mulw | is_mulb | is_divw | is_divb;
   wire is_byte_ar = (opcode[7:4] == 4'h5) | (opcode[7:4] == 4'h7)
                     | (opcode[7:4] == 4'h9) | (opcode[7:4] == 4'hB);
   wire is_muldiv  = is_mulw | is_mulb | is_divw | is_divb;
   wire [1:0] mode = opcode[1:0];

   // ------------------------------------------------------------
   // Operand size and destination layout
   // ------------------------------------------------------------
   wire byte_op = is_arith ? is_byte_ar :
                  (is_single & is_byte_sng) | is_shift_b;
   wire [1:0] size_d = is_long ? cid_pkg::SZ_DWORD :
                       byte_op ? cid_pkg::SZ_BYTE : cid_pkg::SZ_WORD;
   wire [7:0] dst   = (is_arith & is_three) ? byte3 : byte2;
   wire dbl_dst     = is_mulw | is_divw | is_long;
   wire wd_dst      = is_mulb | is_divb | (opcode == cid_pkg::OP_EXTB)
                      | (byte_op == 1'b0);
   wire misalign    = dbl_dst ? (dst[1:0] != 2'h0) :
                      wd_dst  ? dst[0] : 1'b0;
   wire ind_mode    = is_arith & (mode[1] == 1'b1);
   wire odd_b2      = byte2[0];
   wire [7:0] ptr   = {byte2[7:1], 1'b0};

   // ------------------------------------------------------------
   // Branch target and state count
   // ------------------------------------------------------------
   wire [7:0]  disp8  = is_bitjmp ? byte3 : byte2;
   wire [15:0] disp   = {{8{disp8[7]}}, disp8};
   wire        taken  = is_jmp & fl.taken;
   wire [15:0] len    = is_bitjmp ? 16'h0003 : 16'h0002;
   wire [15:0] seq_pc = pc + len;
   wire [15:0] tgt_pc = seq_pc + disp;

   wire [5:0] md_base = is_mulw | is_divw ? cid_pkg::ST_MULU2_DIRECT
                                          : cid_pkg::ST_MULUB_DIRECT;
   wire [5:0] ar_base = is_muldiv ? md_base : cid_pkg::ST_ALU_DIRECT;
   wire [5:0] sgn_add = prefix_q & is_muldiv ? cid_pkg::ST_SIGNED_EXTRA
                                             : 6'h00;
   wire [5:0] thr_add = is_three ? cid_pkg::ST_THREE_EXTRA : 6'h00;
   wire [5:0] imm_add = (mode == cid_pkg::AM_IMMED) & ~byte_op
                        & ~is_mulb ? 6'h01 : 6'h00;
   // Odd second byte costs one more state in both indirect and indexed
   wire [5:0] ind_add = (odd_b2
                         ? cid_pkg::ST_AUTO_EXTRA : cid_pkg::ST_IND_EXTRA)
                        + (operand_external ? cid_pkg::ST_EXT_EXTRA
                                            : 6'h00);
   wire [5:0] ar_cnt  = ar_base + sgn_add + thr_add
                        + (ind_mode ? ind_add : imm_add);
   wire [5:0] cnt_d   =
      is_rst    ? cid_pkg::ST_SW_RESET :
      is_bitjmp ? (taken ? cid_pkg::ST_JB_TAKEN : cid_pkg::ST_JB_NOT) :
      is_jmp    ? (taken ? cid_pkg::ST_JMP_TAKEN : cid_pkg::ST_JMP_NOT) :
      (is_shift | is_shift_b) ? cid_pkg::ST_SHIFT_BASE :
      is_arith  ? ar_cnt : cid_pkg::ST_SINGLE;

   // ------------------------------------------------------------
   // Flag effects
   // ------------------------------------------------------------
   logic [5:0] fl_d;
   always_comb begin
      fl_d = flags_in;
      if (is_vtjmp) begin
         fl_d[cid_pkg::FLAG_VT] = 1'b0;
      end
      if (opcode == cid_pkg::OP_CLRVT) begin
         fl_d[cid_pkg::FLAG_VT] = 1'b0;
      end
      if (opcode == cid_pkg::OP_SETC) begin
         fl_d[cid_pkg::FLAG_C] = 1'b1;
      end
      if (opcode == cid_pkg::OP_CLRC) begin
         fl_d[cid_pkg::FLAG_C] = 1'b0;
      end
      if (is_rst) begin
         fl_d = cid_pkg::FLAGS_RESET;
      end
   end

   wire accept = (state_q == CID_IDLE) & instr_valid;
   wire exec   = accept & ~is_prefix;

   // ------------------------------------------------------------
   // Sequencing
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= CID_IDLE;
         cnt_q   <= 6'h00;
      end else begin
         unique case (state_q)
            CID_IDLE: begin
               if (exec) begin
                  state_q <= is_rst ? CID_RST : CID_EXEC;
                  cnt_q   <= cnt_d - 6'h01;
               end
            end
            CID_EXEC, CID_RST: begin
               if (cnt_q <= 6'h01) begin
                  state_q <= CID_IDLE;
               end
               cnt_q <= cnt_q - 6'h01;
            end
            default: begin
               state_q <= CID_IDLE;
            end
         endcase
      end
   end

   // Prefix lives until the next real opcode consumes it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prefix_q <= 1'b0;
      end else if (accept) begin
         prefix_q <= is_prefix;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busy            <= 1'b0;
         done            <= 1'b0;
         next_pc         <= cid_pkg::RESET_VECTOR;
         flags_out       <= cid_pkg::FLAGS_RESET;
         op_size         <= cid_pkg::SZ_WORD;
         addr_mode       <= cid_pkg::AM_DIRECT;
         auto_inc        <= 1'b0;
         long_index      <= 1'b0;
         dest_addr       <= 8'h00;
         ptr_addr        <= 8'h00;
         dest_misaligned <= 1'b0;
         signed_op       <= 1'b0;
         bit_number      <= 11'h000;
         state_count     <= 6'h00;
         reset_pin_low   <= 1'b0;
      end else begin
         busy          <= (state_q == CID_IDLE) ? exec : (cnt_q > 6'h01);
         done          <= (state_q != CID_IDLE) & (cnt_q <= 6'h01);
         reset_pin_low <= (state_q == CID_IDLE) ? (exec & is_rst)
                          : ((state_q == CID_RST) & (cnt_q > 6'h01));
         if (exec) begin
            next_pc         <= is_rst ? cid_pkg::RESET_VECTOR
                               : taken ? tgt_pc : seq_pc;
            flags_out       <= fl_d;
            op_size         <= size_d;
            addr_mode       <= is_arith ? mode : cid_pkg::AM_DIRECT;
            auto_inc        <= ind_mode & (mode == cid_pkg::AM_INDIRECT) & odd_b2;
            long_index      <= ind_mode & (mode == cid_pkg::AM_INDEXED) & odd_b2;
            dest_addr       <= dst;
            ptr_addr        <= ind_mode ? ptr : 8'h00;
            dest_misaligned <= misalign;
            signed_op       <= prefix_q & is_muldiv;
            bit_number      <= {byte2, opcode[2:0]};
            state_count     <= cnt_d;
         end
      end
   end
endmodule : cid_decode

// >>> verilog/cid_flag_if.sv
`timescale 1ns/1ps
// Flag evaluation request and answer between decoder and condition unit
interface cid_flag_if;
   logic [7:0] opcode;
   logic [5:0] flags;
   logic       bit_value;
   logic       taken;
   modport dec  (output opcode, output flags, output bit_value, input taken);
   modport cond (input opcode, input flags, input bit_value, output taken);
endinterface : cid_flag_if

// >>> verilog/cid_pkg.sv
package cid_pkg;
   // ------------------------------------------------------------
   // Opcodes
   // ------------------------------------------------------------
   localparam logic [7:0] OP_SIGNED_PREFIX = 8'hFE;
   localparam logic [7:0] OP_ADD2_BASE     = 8'h64;
   localparam logic [7:0] OP_MULU2_BASE    = 8'h6C;
   localparam logic [7:0] OP_MULU3_BASE    = 8'h4C;
   localparam logic [7:0] OP_MULUB2_BASE   = 8'h7C;
   localparam logic [7:0] OP_MULUB3_BASE   = 8'h5C;
   localparam logic [7:0] OP_DIVU_BASE     = 8'h8C;
   localparam logic [7:0] OP_DIVUB_BASE    = 8'h9C;
   localparam logic [7:0] OP_JBC_BASE      = 8'h30;
   localparam logic [7:0] OP_JBS_BASE      = 8'h38;
   localparam logic [7:0] OP_JNST          = 8'hD0;
   localparam logic [7:0] OP_JNH           = 8'hD1;
   localparam logic [7:0] OP_JGT           = 8'hD2;
   localparam logic [7:0] OP_JNC           = 8'hD3;
   localparam logic [7:0] OP_JUMP_ON_TRAP_CLEAR          = 8'hD4;
   localparam logic [7:0] OP_JNV           = 8'hD5;
   localparam logic [7:0] OP_JGE           = 8'hD6;
   localparam logic [7:0] OP_JNE           = 8'hD7;
   localparam logic [7:0] OP_JST           = 8'hD8;
   localparam logic [7:0] OP_JH            = 8'hD9;
   localparam logic [7:0] OP_JLE           = 8'hDA;
   localparam logic [7:0] OP_JC            = 8'hDB;
   localparam logic [7:0] OP_JVT           = 8'hDC;
   localparam logic [7:0] OP_JV            = 8'hDD;
   localparam logic [7:0] OP_JLT           = 8'hDE;
   localparam logic [7:0] OP_JE            = 8'hDF;
   localparam logic [7:0] OP_SHR           = 8'h08;
   localparam logic [7:0] OP_SHL           = 8'h09;
   localparam logic [7:0] OP_SHRA          = 8'h0A;
   localparam logic [7:0] OP_SHRL          = 8'h0C;
   localparam logic [7:0] OP_DOUBLE_WORD_LEFT_SHIFT          = 8'h0D;
   localparam logic [7:0] OP_SHRAL         = 8'h0E;
   localparam logic [7:0] OP_EXTB          = 8'h16;
   localparam logic [7:0] OP_CLRC          = 8'hF8;
   localparam logic [7:0] OP_SETC          = 8'hF9;
   localparam logic [7:0] OP_CLRVT         = 8'hFC;
   localparam logic [7:0] OP_SW_RESET      = 8'hFF;
   // ------------------------------------------------------------
   // Addresses, widths and flag positions
   // ------------------------------------------------------------
   localparam logic [15:0] RESET_VECTOR    = 16'h2080;
   localparam int          BIT_SPACE       = 2048;
   localparam int          BIT_NUM_W       = 11;
   localparam int          FLAG_Z          = 5;
   localparam int          FLAG_N          = 4;
   localparam int          FLAG_C          = 3;
   localparam int          FLAG_V          = 2;
   localparam int          FLAG_VT         = 1;
   localparam int          FLAG_ST         = 0;
   localparam logic [5:0]  FLAGS_RESET     = 6'h00;
   // ------------------------------------------------------------
   // Operand size and addressing mode codes
   // ------------------------------------------------------------
   localparam logic [1:0]  SZ_BYTE         = 2'h0;
   localparam logic [1:0]  SZ_WORD         = 2'h1;
   localparam logic [1:0]  SZ_DWORD        = 2'h2;
   localparam logic [1:0]  AM_DIRECT       = 2'h0;
   localparam logic [1:0]  AM_IMMED        = 2'h1;
   localparam logic [1:0]  AM_INDIRECT     = 2'h2;
   localparam logic [1:0]  AM_INDEXED      = 2'h3;
   // ------------------------------------------------------------
   // State-time counts
   // ------------------------------------------------------------
   localparam logic [5:0]  ST_JMP_TAKEN    = 6'h08;
   localparam logic [5:0]  ST_JMP_NOT      = 6'h04;
   localparam logic [5:0]  ST_JB_TAKEN     = 6'h09;
   localparam logic [5:0]  ST_JB_NOT       = 6'h05;
   localparam logic [5:0]  ST_SINGLE       = 6'h04;
   localparam logic [5:0]  ST_SHIFT_BASE   = 6'h07;
   localparam logic [5:0]  ST_SW_RESET     = 6'h10;
   localparam logic [5:0]  ST_ALU_DIRECT   = 6'h04;
   localparam logic [5:0]  ST_EXT_EXTRA    = 6'h05;
   localparam logic [5:0]  ST_MULU2_DIRECT = 6'h19;
   localparam logic [5:0]  ST_MULUB_DIRECT = 6'h11;
   localparam logic [5:0]  ST_SIGNED_EXTRA = 6'h04;
   localparam logic [5:0]  ST_THREE_EXTRA  = 6'h01;
   localparam logic [5:0]  ST_IND_EXTRA    = 6'h02;
   localparam logic [5:0]  ST_AUTO_EXTRA   = 6'h03;
endpackage : cid_pkg
